/* File: core/phs_pkg.sv */
/*
 * Shared constants for the link state report and interrupt enable bank:
 * register indices, field positions, reset values and event bit order.
 * Assumes an APB host whose byte address is four times the register index.
 */
// How it works
// - speed field bits 15-14, 00/01/10 encoding
// - bit 13 one for full duplex
// - page flag latches, cleared by status read
// - bit 11 set when negotiation done/disabled
// - bit 10 shows current link up
// - bit 7 downshift masking, only while negotiating
// - bit 6 reads one while asleep
// - bits 5-2 reversed channels D..A, gigabit only
// - bit 1 one for normal 10M polarity
// - bit 0 one while jabber present
// - interrupt only for enabled events
// - sixteen enable bits, reset zero, fixed order
// - events latch regardless of enable bits
// - interrupt pin active low unless polarity cleared
package phs_pkg;

	localparam int unsigned REG_W = 16;

	// register indices; byte address is index times four
	localparam logic [5:0] IDX_STATUS = 6'h11;
	localparam logic [5:0] IDX_IRQ_EN = 6'h12;
	localparam logic [5:0] IDX_EVT = 6'h13;
	localparam logic [5:0] IDX_CFG = 6'h14;

	// link state report fields
	localparam int unsigned F_SPEED_HI = 15;
	localparam int unsigned F_SPEED_LO = 14;
	localparam int unsigned F_DUPLEX = 13;
	localparam int unsigned F_PAGE = 12;
	localparam int unsigned F_RES_DONE = 11;
	localparam int unsigned F_LINK = 10;
	localparam int unsigned F_XOVER_CD = 9;
	localparam int unsigned F_XOVER_AB = 8;
	localparam int unsigned F_DOWNSHIFT = 7;
	localparam int unsigned F_SLEEP = 6;
	localparam int unsigned F_CHPOL_HI = 5;
	localparam int unsigned F_CHPOL_LO = 2;
	localparam int unsigned F_POL10 = 1;
	localparam int unsigned F_JABBER = 0;

	localparam logic [1:0] SPEED_10 = 2'h0;
	localparam logic [1:0] SPEED_100 = 2'h1;
	localparam logic [1:0] SPEED_1000 = 2'h2;

	// event order, shared by enable and event status registers
	localparam int unsigned EV_NEG_ERROR = 15;
	localparam int unsigned EV_RATE_CHANGE = 14;
	localparam int unsigned EV_DUPLEX_CHANGE = 13;
	localparam int unsigned EV_PAGE = 12;
	localparam int unsigned EV_NEG_DONE = 11;
	localparam int unsigned EV_LINK_CHANGE = 10;
	localparam int unsigned EV_ENERGY_ERR = 9;
	localparam int unsigned EV_FALSE_CARRIER = 8;
	localparam int unsigned EV_CONV_FIFO = 7;
	localparam int unsigned EV_XOVER_CHANGE = 6;
	localparam int unsigned EV_DOWNSHIFT = 5;
	localparam int unsigned EV_POWER_STATE = 4;
	localparam int unsigned EV_WAKE = 3;
	localparam int unsigned EV_MAC_BUF = 2;
	localparam int unsigned EV_POLARITY = 1;
	localparam int unsigned EV_JABBER = 0;

	// configuration register: interrupt pin polarity
	localparam int unsigned F_IRQ_POL = 13;

	localparam logic [15:0] IRQ_EN_RST = 16'h0000;
	localparam logic [15:0] EVT_RST = 16'h0000;
	localparam logic [15:0] CFG_RST = 16'h2000;
	localparam logic [15:0] CFG_MASK = 16'h2000;

endpackage

/* File: core/phs_sticky.sv */
/*
 * Bank of sticky flags: a set pulse latches a bit, a clear pulse drops it.
 * Assumes set and clear are synchronous to pclk; set wins over clear.
 */
module phs_sticky #(
	parameter int unsigned W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] flag_q
);

	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic bit_d;

			// an event landing on the clearing edge must survive
			always_comb
			begin
				bit_d = set[i] | (flag_q[i] & ~clr[i]);
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					flag_q[i] <= 1'b0;
				else
					flag_q[i] <= bit_d;
			end
		end
	endgenerate

endmodule

/* File: core/phs_regs.sv */
/*
 * Link state report, interrupt enable, event status and pin polarity
 * registers behind an APB slave, with the interrupt outputs.
 * Assumes status inputs and event pulses are synchronous to pclk.
 */
// The APB interface to the registers was decided locally.
module phs_regs #(
	parameter int unsigned AW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic [1:0] link_speed,
	input wire logic full_duplex,
	input wire logic page_rx,
	input wire logic neg_enabled,
	input wire logic neg_finished,
	input wire logic link_up,
	input wire logic crossover_pairs_cd,
	input wire logic crossover_pairs_ab,
	input wire logic downshift_active,
	input wire logic sleep_state,
	input wire logic [3:0] channel_polarity_flags,
	input wire logic pol10_normal,
	input wire logic jabber_present,
	input wire logic [15:0] event_pulse,
	output logic irq,
	output logic irq_pin
);

	////////////////////////////////////////////////////////////////////////////
	// address decode

	logic setup;
	logic access;
	logic hit_status;
	logic hit_en;
	logic hit_evt;
	logic hit_cfg;
	logic hit_any;

	function automatic logic idx_hit(input logic [AW-1:0] a, input logic [5:0] idx);
		idx_hit = (a[AW-1:2] == idx[AW-3:0]);
	endfunction

	always_comb
	begin
		hit_status = 1'b0;
		hit_en = 1'b0;
		hit_evt = 1'b0;
		hit_cfg = 1'b0;
		if (idx_hit(paddr, phs_pkg::IDX_STATUS))
			hit_status = 1'b1;
		else if (idx_hit(paddr, phs_pkg::IDX_IRQ_EN))
			hit_en = 1'b1;
		else if (idx_hit(paddr, phs_pkg::IDX_EVT))
			hit_evt = 1'b1;
		else if (idx_hit(paddr, phs_pkg::IDX_CFG))
			hit_cfg = 1'b1;
	end

	assign hit_any = hit_status | hit_en | hit_evt | hit_cfg;
	assign setup = psel & ~penable;
	// zero wait states: read data is captured in the setup cycle
	assign access = psel & penable;
	assign pready = access;

	////////////////////////////////////////////////////////////////////////////
	// live status word

	logic page_q;
	logic gig_link;
	logic negotiating;
	logic [15:0] status_word;

	assign gig_link = link_up & (link_speed == phs_pkg::SPEED_1000);
	assign negotiating = neg_enabled & ~neg_finished;

	always_comb
	begin
		status_word = 16'h0000;
		status_word[phs_pkg::F_SPEED_HI:phs_pkg::F_SPEED_LO] = link_speed;
		status_word[phs_pkg::F_DUPLEX] = full_duplex;
		status_word[phs_pkg::F_PAGE] = page_q;
		status_word[phs_pkg::F_RES_DONE] = ~neg_enabled | neg_finished;
		status_word[phs_pkg::F_LINK] = link_up;
		status_word[phs_pkg::F_XOVER_CD] = crossover_pairs_cd;
		status_word[phs_pkg::F_XOVER_AB] = crossover_pairs_ab;
		// masking is only meaningful while negotiation runs
		status_word[phs_pkg::F_DOWNSHIFT] = downshift_active & negotiating;
		status_word[phs_pkg::F_SLEEP] = sleep_state;
		// per-channel flags are undefined without a gigabit link, so read zero
		if (gig_link)
			status_word[phs_pkg::F_CHPOL_HI:phs_pkg::F_CHPOL_LO] = channel_polarity_flags;
		status_word[phs_pkg::F_POL10] = pol10_normal;
		status_word[phs_pkg::F_JABBER] = jabber_present;
	end

	////////////////////////////////////////////////////////////////////////////
	// read path and clear-on-read snapshot

	logic [15:0] rdata_d;
	logic [15:0] rdata_q;
	logic slverr_d;
	logic slverr_q;
	logic snap_page_d;
	logic snap_page_q;
	logic [15:0] en_q;
	logic [15:0] evt_q;
	logic [15:0] cfg_q;

	always_comb
	begin
		rdata_d = rdata_q;
		slverr_d = slverr_q;
		snap_page_d = snap_page_q;
		if (setup)
		begin
			slverr_d = ~hit_any;
			snap_page_d = 1'b0;
			if (hit_status)
			begin
				rdata_d = status_word;
				snap_page_d = page_q & ~pwrite;
			end
			else if (hit_en)
				rdata_d = en_q;
			else if (hit_evt)
				rdata_d = evt_q;
			else if (hit_cfg)
				rdata_d = cfg_q;
			else
				rdata_d = 16'h0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata_q <= 16'h0000;
			slverr_q <= 1'b0;
			snap_page_q <= 1'b0;
		end
		else
		begin
			rdata_q <= rdata_d;
			slverr_q <= slverr_d;
			snap_page_q <= snap_page_d;
		end
	end

	// registers are sixteen bits; upper lanes always read zero
	assign prdata = {16'h0000, rdata_q};
	assign pslverr = slverr_q & access;

	////////////////////////////////////////////////////////////////////////////
	// writable registers

	logic wr_en;
	logic wr_evt;
	logic wr_cfg;
	logic rd_status_done;
	logic [15:0] lane_mask;
	logic [15:0] en_d;
	logic [15:0] cfg_d;

	assign wr_en = access & pwrite & hit_en;
	assign wr_evt = access & pwrite & hit_evt;
	assign wr_cfg = access & pwrite & hit_cfg;
	assign rd_status_done = access & ~pwrite & hit_status;
	assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	always_comb
	begin
		en_d = en_q;
		cfg_d = cfg_q;
		if (wr_en)
			en_d = (en_q & ~lane_mask) | (pwdata[15:0] & lane_mask);
		if (wr_cfg)
			cfg_d = (cfg_q & ~(lane_mask & phs_pkg::CFG_MASK)) | (pwdata[15:0] & lane_mask & phs_pkg::CFG_MASK);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en_q <= phs_pkg::IRQ_EN_RST;
			cfg_q <= phs_pkg::CFG_RST;
		end
		else
		begin
			en_q <= en_d;
			cfg_q <= cfg_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sticky flags

	logic [15:0] evt_set;
	logic [15:0] evt_clr;

	always_comb
	begin
		evt_set = event_pulse;
		evt_set[phs_pkg::EV_PAGE] = event_pulse[phs_pkg::EV_PAGE] | page_rx;
	end

	// write one to clear; a new event in the same cycle stays set
	assign evt_clr = wr_evt ? (pwdata[15:0] & lane_mask) : 16'h0000;

	phs_sticky #(
		.W(16)
	) u_evt (
		.pclk(pclk),
		.presetn(presetn),
		.set(evt_set),
		.clr(evt_clr),
		.flag_q(evt_q)
	);

	// only a page seen in the snapshot is cleared, so a later one survives
	phs_sticky #(
		.W(1)
	) u_page (
		.pclk(pclk),
		.presetn(presetn),
		.set(page_rx),
		.clr(rd_status_done & snap_page_q),
		.flag_q(page_q)
	);

	////////////////////////////////////////////////////////////////////////////
	// interrupt outputs

	assign irq = |(evt_q & en_q);
	// polarity bit set drives the pin low when active
	assign irq_pin = cfg_q[phs_pkg::F_IRQ_POL] ? ~irq : irq;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_setup_status;
		setup && hit_status && !pwrite;
	endsequence

	sequence s_read_clear;
		access && hit_status && !pwrite && snap_page_q && !page_rx;
	endsequence

	a_read_speed: assert property (s_setup_status |=> prdata[15:14] == $past(link_speed))
		else $error("speed field mismatch");

	a_read_duplex: assert property (s_setup_status |=> prdata[13] == $past(full_duplex))
		else $error("duplex bit mismatch");

	a_page_set: assert property (page_rx |=> page_q [* 1])
		else $error("page flag not latched");

	a_page_cleared: assert property (s_setup_status ##1 s_read_clear |=> !page_q)
		else $error("page flag not cleared by read");

	a_page_holds: assert property (page_q && !rd_status_done |=> page_q)
		else $error("page flag dropped without read");

	a_res_done: assert property (s_setup_status |=> prdata[11] == ($past(neg_finished) || !$past(neg_enabled)))
		else $error("resolution bit mismatch");

	a_read_link: assert property (s_setup_status |=> prdata[10] == $past(link_up))
		else $error("link bit mismatch");

	a_read_xover: assert property (s_setup_status |=> prdata[9:8] == {$past(crossover_pairs_cd), $past(crossover_pairs_ab)})
		else $error("crossover bits mismatch");

	a_downshift_gate: assert property ((s_setup_status and !negotiating) |=> prdata[7] == 1'b0)
		else $error("downshift shown outside negotiation");

	a_read_sleep: assert property (s_setup_status |=> prdata[6] == $past(sleep_state))
		else $error("sleep bit mismatch");

	a_chpol_gate: assert property ((s_setup_status and !gig_link) |=> prdata[5:2] == 4'h0)
		else $error("channel polarity shown without gigabit link");

	a_read_pol10: assert property (s_setup_status |=> prdata[1] == $past(pol10_normal))
		else $error("10M polarity bit mismatch");

	a_read_jabber: assert property (s_setup_status |=> prdata[0] == $past(jabber_present))
		else $error("jabber bit mismatch");

	a_irq_needs_en: assert property (en_q == 16'h0000 |-> !irq)
		else $error("interrupt without any enable");

	a_irq_raised: assert property ((event_pulse & en_q) != 16'h0000 && !wr_en |=> irq)
		else $error("enabled event raised no interrupt");

	a_en_write: assert property (wr_en && pstrb[1:0] == 2'h3 |=> en_q == $past(pwdata[15:0]))
		else $error("enable register not written");

	a_evt_latch: assert property (event_pulse[phs_pkg::EV_JABBER] |=> evt_q[phs_pkg::EV_JABBER])
		else $error("event not latched");

	a_pin_polarity: assert property (irq_pin == (cfg_q[phs_pkg::F_IRQ_POL] ? !irq : irq))
		else $error("interrupt pin polarity wrong");

	a_upper_zero: assert property (access && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper read lanes not zero");

	a_unmapped_err: assert property (setup && !hit_any ##1 access |-> pslverr)
		else $error("unmapped access without error");

endmodule

/* File: tb/phs_host.sv */
/*
 * APB master model standing in for the station management host.
 * Assumes pclk from the bench; the slave may add wait states.
 */
module phs_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// byte address is index times four; software sets enables itself
	task automatic xfer(input logic w, input logic [5:0] idx, input logic [15:0] wd, input logic [1:0] strb,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= {16'h0000, wd};
		pstrb <= {2'h0, strb};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no cycle limit here: only the bench watchdog ends a stuck wait
		while (pready !== 1'b1)
		begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines show no stale value
		paddr <= ~paddr;
		pwdata <= ~pwdata;
	endtask
endmodule

/* File: tb/phs_regs_test.sv */
/*
 * Self-checking bench for the link state report and interrupt enable bank.
 * Assumes phs_host drives APB; status and event inputs come from here.
 */
module phs_regs_test;
	timeunit 1ns;
	timeprecision 1ps;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, irq_pin, err, pg;
	logic dup, page_rx, neg_en, neg_fin, link, xcd, xab, ds, sleep, pol10, jab;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb, chpol;
	logic [1:0] speed, sb;
	logic [15:0] ev_pulse, en_m, ev_m, wd, exp_s;
	logic [15:0] exp_q[$];
	int miscompares, checks, seed, b;

	phs_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr));

	phs_regs #(.AW(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .link_speed(speed), .full_duplex(dup), .page_rx(page_rx),
		.neg_enabled(neg_en), .neg_finished(neg_fin), .link_up(link), .crossover_pairs_cd(xcd),
		.crossover_pairs_ab(xab), .downshift_active(ds), .sleep_state(sleep),
		.channel_polarity_flags(chpol), .pol10_normal(pol10), .jabber_present(jab),
		.event_pulse(ev_pulse), .irq(irq), .irq_pin(irq_pin));

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic settle();
		@(posedge pclk);
		#1;
	endtask

	task automatic pulse(input logic [15:0] ev);
		@(posedge pclk);
		ev_pulse <= ev;
		@(posedge pclk);
		ev_pulse <= 16'h0000;
		ev_m = ev_m | ev;
	endtask

	// gigabit polarity is masked without a gigabit link
	function automatic logic [15:0] exp_status();
		logic [3:0] cp;
		cp = (link && speed == phs_pkg::SPEED_1000) ? chpol : 4'h0;
		return {speed, dup, pg, ~neg_en | neg_fin, link, xcd, xab, ds & neg_en & ~neg_fin, sleep, cp, pol10, jab};
	endfunction

	initial
	begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		summarize();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		presetn = 1'b0;
		seed = 32'h8e64;
		{dup, page_rx, neg_en, neg_fin, link, xcd, xab, ds, sleep, pol10, jab} = 11'h000;
		speed = 2'h0;
		chpol = 4'h0;
		ev_pulse = 16'h0000;
		pg = 1'b0;
		en_m = 16'h0000;
		ev_m = 16'h0000;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		settle();
		check("irq", irq, 0);
		check("irq_pin", irq_pin, 1);
		host.xfer(1'b0, phs_pkg::IDX_IRQ_EN, 16'h0000, 2'h0, rd, err);
		check("enable", rd, 0);
		host.xfer(1'b0, phs_pkg::IDX_EVT, 16'h0000, 2'h0, rd, err);
		check("events", rd, 0);
		for (b = 0; b < 24; b++)
		begin
			@(posedge pclk);
			speed <= 2'($unsigned($random(seed)) % 3);
			chpol <= 4'($random(seed));
			{dup, neg_en, neg_fin, link, xcd, xab, ds, sleep, pol10, jab} <= 10'($random(seed));
			host.xfer(1'b0, phs_pkg::IDX_STATUS, 16'h0000, 2'h0, rd, err);
			exp_q.push_back(exp_status());
			exp_s = exp_q.pop_front();
			check("status hi", rd[31:8], {16'h0000, exp_s[15:8]});
			check("status lo", rd[7:0], exp_s[7:0]);
		end
		pulse(16'h0000);
		@(posedge pclk);
		page_rx <= 1'b1;
		@(posedge pclk);
		page_rx <= 1'b0;
		pg = 1'b1;
		ev_m[phs_pkg::EV_PAGE] = 1'b1;
		host.xfer(1'b0, phs_pkg::IDX_STATUS, 16'h0000, 2'h0, rd, err);
		check("status page set", rd, {16'h0000, exp_status()});
		pg = 1'b0;
		host.xfer(1'b0, phs_pkg::IDX_STATUS, 16'h0000, 2'h0, rd, err);
		check("status page clear", rd, {16'h0000, exp_status()});
		host.xfer(1'b0, phs_pkg::IDX_EVT, 16'h0000, 2'h0, rd, err);
		check("events after status read", rd, {16'h0000, ev_m});
		for (b = 0; b < 8; b++)
		begin
			wd = 16'($random(seed));
			sb = 2'($random(seed));
			host.xfer(1'b1, phs_pkg::IDX_IRQ_EN, wd, sb, rd, err);
			if (sb[0])
				en_m[7:0] = wd[7:0];
			if (sb[1])
				en_m[15:8] = wd[15:8];
			host.xfer(1'b0, phs_pkg::IDX_IRQ_EN, 16'h0000, 2'h0, rd, err);
			check("enable rw", rd, {16'h0000, en_m});
			check("mapped no error", err, 0);
		end
		host.xfer(1'b1, 6'h20, 16'hffff, 2'h3, rd, err);
		check("unmapped error", err, 1);
		host.xfer(1'b1, phs_pkg::IDX_IRQ_EN, 16'h0000, 2'h3, rd, err);
		host.xfer(1'b1, phs_pkg::IDX_EVT, 16'hffff, 2'h3, rd, err);
		en_m = 16'h0000;
		ev_m = 16'h0000;
		// each event: latched while masked, irq only once enabled
		for (b = 0; b < 16; b++)
		begin
			pulse(16'h0001 << b);
			settle();
			check("irq masked", irq, 0);
			host.xfer(1'b0, phs_pkg::IDX_EVT, 16'h0000, 2'h0, rd, err);
			check("event latched", rd, {16'h0000, ev_m});
			host.xfer(1'b1, phs_pkg::IDX_IRQ_EN, 16'h0001 << b, 2'h3, rd, err);
			settle();
			check("irq enabled", irq, 1);
			check("irq_pin low", irq_pin, 0);
			host.xfer(1'b1, phs_pkg::IDX_EVT, 16'h0001 << b, 2'h3, rd, err);
			ev_m = 16'h0000;
			settle();
			check("irq cleared", irq, 0);
			host.xfer(1'b1, phs_pkg::IDX_IRQ_EN, 16'h0000, 2'h3, rd, err);
		end
		host.xfer(1'b1, phs_pkg::IDX_CFG, 16'h0000, 2'h3, rd, err);
		pulse(16'h0001);
		host.xfer(1'b1, phs_pkg::IDX_IRQ_EN, 16'h0001, 2'h3, rd, err);
		settle();
		check("irq_pin high", irq_pin, 1);
		// mid-run reset must bring back every reset value, pin polarity too
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		settle();
		check("irq after reset", irq, 0);
		check("irq_pin after reset", irq_pin, 1);
		host.xfer(1'b0, phs_pkg::IDX_IRQ_EN, 16'h0000, 2'h0, rd, err);
		check("enable after reset", rd, 0);
		host.xfer(1'b0, phs_pkg::IDX_EVT, 16'h0000, 2'h0, rd, err);
		check("events after reset", rd, 0);
		summarize();
	end
endmodule
